// ===== splc_partner.sv
// Purpose: link controller stand-in facing the serial link pins
// Assumes: a pin enable is high while the device drives that pin
// Notes:   its bit clock stands still low unless run is set
module splc_partner (
    // control
    input  wire logic run,
    // device pins
    input  wire logic bitclk_o,
    input  wire logic bitclk_oe,
    input  wire logic fsync_o,
    input  wire logic fsync_oe,
    input  wire logic sdata_to_partner,
    // resolved wire levels
    output logic      bitclk_i,
    output logic      fsync_i,
    output logic      sdata_from_partner
);
    timeunit 1ns;
    timeprecision 1ps;
    logic bclk_drv;
    logic fs_drv;
    logic sd_drv;
    int   nbit;
    // whoever holds the enable owns the wire
    assign bitclk_i = bitclk_oe ? bitclk_o : bclk_drv;
    assign fsync_i = fsync_oe ? fsync_o : fs_drv;
    assign sdata_from_partner = sd_drv;
    // 80 ns link clock; frame sync one bit in sixteen
    initial begin
        bclk_drv = 1'b0;
        fs_drv = 1'b0;
        sd_drv = 1'b0;
        nbit = 0;
        forever begin
            #40;
            if (run) begin
                bclk_drv = ~bclk_drv;
                if (!bclk_drv) begin
                    nbit++;
                    fs_drv = (nbit % 16 == 0);
                    sd_drv = 1'($urandom);
                end
            end else begin
                // idle data wiggles so a stale level is never trusted
                bclk_drv = 1'b0;
                fs_drv = 1'b0;
                sd_drv = ~sd_drv;
            end
        end
    end
endmodule // splc_partner

// ===== splc_pkg.sv
// Purpose: shared constants, modes and field layouts for the serial link
//          pin and clock setup block
// Assumes: 32-bit apb data, byte addresses, one word per register
// Notes:   rate figures are in kHz so all derivations stay integer
package splc_pkg;

    // -----------------------------------------------------------------
    // interface modes, decoded from the two straps
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        SPLC_PRIMARY = 2'b00,
        SPLC_SEC_01  = 2'b01,
        SPLC_SEC_10  = 2'b10,
        SPLC_DSP     = 2'b11
    } splc_mode_e;

    // -----------------------------------------------------------------
    // register map
    // -----------------------------------------------------------------
    localparam logic [7:0]  SPLC_STATUS_OFF = 8'h58;
    localparam logic [7:0]  SPLC_CTRL_OFF   = 8'h5C;
    localparam logic [31:0] SPLC_CTRL_RESET = 32'h0000_0003;
    localparam logic [31:0] SPLC_CTRL_MASK  = 32'h0000_003F;
    localparam logic [31:0] SPLC_BAD_DATA   = 32'h0000_0000;

    // control word: last member sits in bit 0
    typedef struct packed {
        logic [1:0] pd_depth;            // bits 5:4
        logic [1:0] crystal_rate_select; // bits 3:2
        logic       bufclk_enable_a;     // bit 1
        logic       bufclk_enable_d;     // bit 0
    } splc_ctrl_s;

    // status word
    typedef struct packed {
        logic       clkout_on;   // bit 4
        logic       power_down;  // bit 3
        logic       locked;      // bit 2
        splc_mode_e mode;        // bits 1:0
    } splc_status_s;

    localparam int SPLC_CTRL_W = 6;
    localparam int SPLC_STAT_W = 5;

    // power-down depth thresholds
    localparam logic [1:0] SPLC_PD_CLKOUT = 2'h1;
    localparam logic [1:0] SPLC_PD_XTAL   = 2'h2;

    // -----------------------------------------------------------------
    // clock rates and derived divider increments
    // -----------------------------------------------------------------
    localparam int SPLC_REF0_KHZ     = 12288;
    localparam int SPLC_REF1_KHZ     = 24576;
    localparam int SPLC_REF2_KHZ     = 32768;
    localparam int SPLC_PRI_BCLK_KHZ = 12288;
    localparam int SPLC_DSP_BCLK_KHZ = 4096;
    localparam int SPLC_DSP_FS_KHZ   = 8;
    localparam int SPLC_ACC_MOD      = 24;
    localparam int SPLC_FS_DIV       = SPLC_DSP_BCLK_KHZ / SPLC_DSP_FS_KHZ;

    localparam logic [5:0] SPLC_MOD6 = 6'(SPLC_ACC_MOD);
    localparam logic [5:0] SPLC_INC_P0 =
        6'(SPLC_ACC_MOD * SPLC_PRI_BCLK_KHZ / SPLC_REF0_KHZ);
    localparam logic [5:0] SPLC_INC_P1 =
        6'(SPLC_ACC_MOD * SPLC_PRI_BCLK_KHZ / SPLC_REF1_KHZ);
    localparam logic [5:0] SPLC_INC_P2 =
        6'(SPLC_ACC_MOD * SPLC_PRI_BCLK_KHZ / SPLC_REF2_KHZ);
    localparam logic [5:0] SPLC_INC_D0 =
        6'(SPLC_ACC_MOD * SPLC_DSP_BCLK_KHZ / SPLC_REF0_KHZ);
    localparam logic [5:0] SPLC_INC_D1 =
        6'(SPLC_ACC_MOD * SPLC_DSP_BCLK_KHZ / SPLC_REF1_KHZ);
    localparam logic [5:0] SPLC_INC_D2 =
        6'(SPLC_ACC_MOD * SPLC_DSP_BCLK_KHZ / SPLC_REF2_KHZ);

endpackage

// ===== splc_top.sv
// Purpose: pin direction, strap latch, clock generation and power-down
//          handling for the serial link of a modem codec
// Assumes: reset_n is the internal power-on reset; all pins asynchronous
// Notes:   apb slave answers one wait state after the access phase starts
// Operation
// [RULE_01] bit clock pin drives out in primary and dsp, input in secondaries
// [RULE_02] frame sync pin drives out only in dsp, input in link modes
// [RULE_03] serial data always driven out and always sampled in
// [RULE_04] reference clock is used only in primary or dsp mode; the clock output pin still copies it in secondary modes
// [RULE_05] clock output pin copies reference clock unless enable bits clear
// [RULE_06] low reset pin requests power-down; depth from control bits
// [RULE_07] only power-on reset clears state; reset pin keeps registers
// [RULE_08] partner holds reset pin low until supply has settled
// [RULE_09] straps latched at first reset pin release, held until power-off
// [RULE_10] primary mode makes a 12.288 MHz bit clock, takes frame sync
// [RULE_11] crystal rate field tells which reference frequency is fitted
// [RULE_12] latched mode, cleared by power-on only, selects pin enables
module splc_top
    import splc_pkg::*;
(
    // clock and power-on reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // clock pins
    input  wire logic        reference_clock_input,
    output logic             crystal_drive_output,
    output logic             clk_out_pin,
    // reset pin and mode straps
    input  wire logic        link_reset_pin_n,
    input  wire logic        strap_hi_pin,
    input  wire logic        strap_lo_pin,
    // bit clock pin
    input  wire logic        bitclk_i,
    output logic             bitclk_o,
    output logic             bitclk_oe,
    // frame sync pin
    input  wire logic        fsync_i,
    output logic             fsync_o,
    output logic             fsync_oe,
    // serial data pins
    output logic             sdata_to_partner,
    input  wire logic        sdata_from_partner,
    // user side
    input  wire logic        tx_bit,
    output logic             rx_bit,
    output logic             link_bit_rise,
    output logic             link_frame_rise,
    output logic             power_down,
    output logic             mode_locked,
    output logic      [1:0]  mode_out
);

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [2:0] ref_s, rst_s, bck_s, fs_s;
    logic [1:0] shi_s, slo_s, rx_s;

    // pins all land in reset low; the reset pin is low at power-up anyway
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_s <= 3'h0;
            rst_s <= 3'h0;
            bck_s <= 3'h0;
            fs_s  <= 3'h0;
            shi_s <= 2'h0;
            slo_s <= 2'h0;
            rx_s  <= 2'h0;
        end else begin
            ref_s <= {ref_s[1:0], reference_clock_input};
            rst_s <= {rst_s[1:0], link_reset_pin_n};
            bck_s <= {bck_s[1:0], bitclk_i};
            fs_s  <= {fs_s[1:0], fsync_i};
            shi_s <= {shi_s[0], strap_hi_pin};
            slo_s <= {slo_s[0], strap_lo_pin};
            rx_s  <= {rx_s[0], sdata_from_partner}; // [RULE_03]
        end
    end

    // stage 0 of each chain is read only by stage 1
    wire pd_req      = ~rst_s[1];                 // [RULE_06]
    wire rst_release = rst_s[1] & ~rst_s[2];
    wire ref_edge    = ref_s[1] ^ ref_s[2];
    wire bck_rise_in = bck_s[1] & ~bck_s[2];
    wire fs_rise_in  = fs_s[1] & ~fs_s[2];

    // ---------------------------------------------------------------
    // mode latch
    // ---------------------------------------------------------------
    splc_mode_e mode_r;
    logic       locked_r;
    // high/high gives primary, low/low dsp: the code is the inverted pins
    wire splc_mode_e strap_mode = splc_mode_e'({~shi_s[1], ~slo_s[1]});
    wire lock_evt = rst_release & ~locked_r;

    // only power-on reset clears the latch; later releases are ignored
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_r   <= SPLC_PRIMARY;      // [RULE_12]
            locked_r <= 1'b0;
        end else if (lock_evt) begin
            mode_r   <= strap_mode;        // [RULE_09]
            locked_r <= 1'b1;
        end
    end

    wire is_dsp    = (mode_r == SPLC_DSP);
    wire is_master = (mode_r == SPLC_PRIMARY) | is_dsp;
    wire is_slave  = ~is_master;

    // ---------------------------------------------------------------
    // apb slave
    // ---------------------------------------------------------------
    splc_ctrl_s ctrl_r;
    logic       pready_r, pslverr_r;
    logic [31:0] prdata_r;
    splc_status_s status_w;

    wire hit_ctrl = (paddr == SPLC_CTRL_OFF);
    wire hit_stat = (paddr == SPLC_STATUS_OFF);
    wire acc_go   = psel & penable & ~pready_r;
    wire wr_en    = psel & penable & pready_r & pwrite & hit_ctrl;
    wire [31:0] rd_mux =
        hit_ctrl ? {{(32 - SPLC_CTRL_W){1'b0}}, ctrl_r} :
        hit_stat ? {{(32 - SPLC_STAT_W){1'b0}}, status_w} : SPLC_BAD_DATA;

    // one wait state: answer registered so pready comes from a flop
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= acc_go;
            pslverr_r <= acc_go & ~hit_ctrl & ~hit_stat;
            prdata_r  <= acc_go ? rd_mux : 32'h0000_0000;
        end
    end

    // control survives the reset pin, it is cleared by power-on only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            ctrl_r <= splc_ctrl_s'(SPLC_CTRL_RESET[SPLC_CTRL_W-1:0]);
        else if (wr_en)
            ctrl_r <= splc_ctrl_s'(pwdata[SPLC_CTRL_W-1:0]); // [RULE_07]
    end

    // ---------------------------------------------------------------
    // clock output and crystal drive
    // ---------------------------------------------------------------
    wire deep_clk  = pd_req & (ctrl_r.pd_depth >= SPLC_PD_CLKOUT);
    wire deep_xtal = pd_req & (ctrl_r.pd_depth >= SPLC_PD_XTAL);
    wire clkout_en = ctrl_r.bufclk_enable_d & ctrl_r.bufclk_enable_a
                   & ~deep_clk;                               // [RULE_05]
    // secondaries never need the crystal, so its drive is off there
    wire xtal_en   = locked_r & is_master & ~deep_xtal;      // [RULE_04]

    // ---------------------------------------------------------------
    // bit clock generator: fractional divide of reference edges
    // ---------------------------------------------------------------
    // both edges of the reference are counted; toggles come on wrap
    wire [5:0] inc_w =
        (ctrl_r.crystal_rate_select == 2'h1) ? (is_dsp ? SPLC_INC_D1
                                                       : SPLC_INC_P1) :
        (ctrl_r.crystal_rate_select == 2'h2) ? (is_dsp ? SPLC_INC_D2
                                                       : SPLC_INC_P2) :
                                               (is_dsp ? SPLC_INC_D0
                                                       : SPLC_INC_P0);
    wire gen_run = locked_r & is_master & ~pd_req;  // [RULE_04]
    logic [5:0] acc_r;
    logic       bclk_r;
    wire  [5:0] acc_sum = acc_r + inc_w;
    wire        acc_wrap = acc_sum >= SPLC_MOD6;
    wire        gen_tog  = gen_run & ref_edge & acc_wrap;   // [RULE_11]
    wire        gen_rise = gen_tog & ~bclk_r;
    wire  [5:0] acc_nxt  = acc_wrap ? acc_sum - SPLC_MOD6 : acc_sum;

    // generator held low and cleared whenever it may not run
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_r  <= 6'h00;
            bclk_r <= 1'b0;
        end else if (!gen_run) begin
            acc_r  <= 6'h00;
            bclk_r <= 1'b0;                           // [RULE_06]
        end else if (ref_edge) begin
            acc_r  <= acc_nxt;
            bclk_r <= bclk_r ^ acc_wrap;              // [RULE_10]
        end
    end

    // dsp frame sync: high for one bit clock period every FS_DIV bits
    localparam int FSW = $clog2(SPLC_FS_DIV);
    logic [FSW-1:0] fs_cnt_r;
    logic           fs_gen_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fs_cnt_r <= '0;
            fs_gen_r <= 1'b0;
        end else if (!(gen_run & is_dsp)) begin
            fs_cnt_r <= '0;
            fs_gen_r <= 1'b0;
        end else if (gen_rise) begin
            fs_cnt_r <= fs_cnt_r + 1'b1;
            fs_gen_r <= (fs_cnt_r == '0);
        end
    end

    // ---------------------------------------------------------------
    // registered outputs
    // ---------------------------------------------------------------
    assign status_w = '{clkout_on: clkout_en, power_down: pd_req,
                        locked: locked_r, mode: mode_r};

    // enables come straight from the latched mode; none before lock
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bitclk_oe            <= 1'b0;
            fsync_oe             <= 1'b0;
            bitclk_o             <= 1'b0;
            fsync_o              <= 1'b0;
            clk_out_pin          <= 1'b0;
            crystal_drive_output <= 1'b0;
            sdata_to_partner     <= 1'b0;
            link_bit_rise        <= 1'b0;
            link_frame_rise      <= 1'b0;
            power_down           <= 1'b1;  // the pin is low at power-up
        end else begin
            bitclk_oe            <= locked_r & is_master;     // [RULE_01]
            fsync_oe             <= locked_r & is_dsp;        // [RULE_02]
            bitclk_o             <= bclk_r;
            fsync_o              <= fs_gen_r;
            clk_out_pin          <= clkout_en & ref_s[1];     // [RULE_05]
            crystal_drive_output <= xtal_en & ~ref_s[1];
            sdata_to_partner     <= tx_bit;                   // [RULE_03]
            link_bit_rise        <= is_slave ? bck_rise_in : gen_rise;
            link_frame_rise      <= is_dsp ? 1'b0 : fs_rise_in; // [RULE_10]
            power_down           <= ~rst_s[1];                // [RULE_06]
        end
    end

    assign rx_bit      = rx_s[1];
    assign prdata      = prdata_r;
    assign pready      = pready_r;
    assign pslverr     = pslverr_r;
    assign mode_locked = locked_r;
    assign mode_out    = mode_r;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    property p_bitclk_dir;
        @(posedge clk) disable iff (!reset_n)
        locked_r |=> bitclk_oe == $past(is_master);
    endproperty
    a_bitclk_dir: assert property (p_bitclk_dir) // [RULE_01]
        else $error("bit clock enable does not follow mode");
    property p_fsync_dir;
        @(posedge clk) disable iff (!reset_n)
        (locked_r && !is_dsp) |=> !fsync_oe && !fsync_o;
    endproperty
    a_fsync_dir: assert property (p_fsync_dir) // [RULE_02]
        else $error("frame sync driven outside dsp mode");
    property p_sdata;
        @(posedge clk) disable iff (!reset_n)
        1'b1 |=> sdata_to_partner == $past(tx_bit);
    endproperty
    a_sdata: assert property (p_sdata) // [RULE_03]
        else $error("serial data out not following tx bit");
    property p_no_ref_slave;
        @(posedge clk) disable iff (!reset_n)
        (locked_r && is_slave) |=> ##1 !bitclk_o && !crystal_drive_output;
    endproperty
    a_no_ref_slave: assert property (p_no_ref_slave) // [RULE_04]
        else $error("reference clock used in secondary mode");
    property p_clkout;
        @(posedge clk) disable iff (!reset_n)
        clkout_en |=> clk_out_pin == $past(ref_s[1]);
    endproperty
    a_clkout: assert property (p_clkout) // [RULE_05]
        else $error("clock output is not the buffered reference");
    property p_pd_stops;
        @(posedge clk) disable iff (!reset_n)
        pd_req [*2] |=> !bitclk_o;
    endproperty
    a_pd_stops: assert property (p_pd_stops) // [RULE_06]
        else $error("bit clock runs during power-down");

    property p_ctrl_keep;
        @(posedge clk) disable iff (!reset_n)
        (pd_req && !wr_en) |=> $stable(ctrl_r);
    endproperty
    a_ctrl_keep: assert property (p_ctrl_keep) // [RULE_07]
        else $error("control changed by reset pin");

    property p_lock;
        @(posedge clk) disable iff (!reset_n)
        lock_evt |=> locked_r && mode_r == $past(strap_mode);
    endproperty
    a_lock: assert property (p_lock) // [RULE_09]
        else $error("strap mode not latched at first release");

    property p_hold;
        @(posedge clk) disable iff (!reset_n)
        locked_r |=> locked_r && $stable(mode_r);
    endproperty
    a_hold: assert property (p_hold) // [RULE_09]
        else $error("latched mode changed");

    property p_pri_rate;
        @(posedge clk) disable iff (!reset_n)
        (gen_run && !is_dsp && ctrl_r.crystal_rate_select == 2'h0
         && ref_edge) |=> bclk_r != $past(bclk_r);
    endproperty
    a_pri_rate: assert property (p_pri_rate) // [RULE_10]
        else $error("primary bit clock misses a reference edge");

    property p_unlocked;
        @(posedge clk) disable iff (!reset_n)
        !locked_r |=> !bitclk_oe && !fsync_oe;
    endproperty
    a_unlocked: assert property (p_unlocked) // [RULE_12]
        else $error("pin driven before mode latched");

    c_lock_dsp: cover property (@(posedge clk) disable iff (!reset_n)
        lock_evt && strap_mode == SPLC_DSP);
    c_lock_pri: cover property (@(posedge clk) disable iff (!reset_n)
        lock_evt && strap_mode == SPLC_PRIMARY);
    c_fsync: cover property (@(posedge clk) disable iff (!reset_n)
        $rose(fsync_o));
    c_write: cover property (@(posedge clk) disable iff (!reset_n) wr_en);

endmodule // splc_top

// ===== testbench.sv
// Purpose: self-checking bench for the link pin and clock setup block
// Assumes: apb slave answers on its own; reference is an async pin
// Notes:   clock rate checks allow a few edges of sampling slack
module testbench;
    import splc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, wd;
    logic pready, pslverr, er, refclk = 0, link_pin_n = 0;
    logic strap_hi = 1, strap_lo = 1, tx_bit = 0, rx_bit, link_run = 0;
    logic xdrv, cko, bitclk_i, bitclk_o, bitclk_oe, fsync_i, fsync_o;
    logic fsync_oe, sd_out, sd_in, bit_rise, frame_rise, power_down;
    logic mode_locked, tx_sh, sd_p1, sd_p2, cnt_en = 0, ref_run = 1, fr_ok;
    logic [1:0] mode_out, mb;
    real ref_half = 40.69;
    int n_mismatch = 0, cmp_count = 0;
    int nref, nbo, ncko, nbi, nfs, nbr, nfr;
    splc_top u_dut (.clk(clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .reference_clock_input(refclk),
        .crystal_drive_output(xdrv), .clk_out_pin(cko),
        .link_reset_pin_n(link_pin_n), .strap_hi_pin(strap_hi),
        .strap_lo_pin(strap_lo), .bitclk_i(bitclk_i),
        .bitclk_o(bitclk_o), .bitclk_oe(bitclk_oe), .fsync_i(fsync_i),
        .fsync_o(fsync_o), .fsync_oe(fsync_oe),
        .sdata_to_partner(sd_out), .sdata_from_partner(sd_in),
        .tx_bit(tx_bit), .rx_bit(rx_bit), .link_bit_rise(bit_rise),
        .link_frame_rise(frame_rise), .power_down(power_down),
        .mode_locked(mode_locked), .mode_out(mode_out));
    splc_partner u_peer (.run(link_run), .bitclk_o(bitclk_o),
        .bitclk_oe(bitclk_oe), .fsync_o(fsync_o), .fsync_oe(fsync_oe),
        .sdata_to_partner(sd_out), .bitclk_i(bitclk_i),
        .fsync_i(fsync_i), .sdata_from_partner(sd_in));
    // ------------------------------------------------------------
    // clocks, shadows and edge counters
    // ------------------------------------------------------------
    always #5 clk = ~clk;
    always begin
        #(ref_half);
        if (ref_run) refclk = ~refclk;
    end
    // shadows mirror the one-flop and two-flop paths
    always @(posedge clk) begin
        tx_sh <= tx_bit;
        sd_p1 <= sd_in;
        sd_p2 <= sd_p1;
        if (cnt_en && bit_rise) nbr++;
        if (cnt_en && frame_rise) nfr++;
    end
    always @(posedge refclk) if (cnt_en) nref++;
    always @(posedge bitclk_o) if (cnt_en) nbo++;
    always @(posedge cko) if (cnt_en) ncko++;
    always @(posedge bitclk_i) if (cnt_en) nbi++;
    always @(posedge fsync_i) if (cnt_en) nfs++;
    // ------------------------------------------------------------
    // tasks and expectations
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s exp %0h got %0h", nm, e, g);
        end
    endtask
    task automatic near(input string nm, input int e, input int g);
        cmp_count++;
        if (g < e - 3 || g > e + 3) begin
            n_mismatch++;
            $display("MISMATCH %s exp %0d got %0d", nm, e, g);
        end
    endtask
    // one apb transfer; pready is read before this edge's updates land
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // no cycle count is assumed; a stuck slave is left to the watchdog
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic measure(input int n);
        @(negedge clk);
        {nref, nbo, ncko, nbi, nfs, nbr, nfr} = '0;
        cnt_en = 1'b1;
        repeat (n) @(posedge clk);
        cnt_en = 1'b0;
    endtask
    // power-on reset with the link pin held low throughout
    task automatic power_up(input logic hi, input logic lo);
        @(posedge clk);
        reset_n <= 1'b0;
        link_pin_n <= 1'b0;
        strap_hi <= hi;
        strap_lo <= lo;
        link_run <= 1'b0;
        // data idles low so the copy taken at the release edge is known
        tx_bit <= 1'b0;
        repeat (20) @(posedge clk);
        chk("locked in reset", 0, 32'(mode_locked));
        chk("bclk oe in reset", 0, 32'(bitclk_oe));
        reset_n <= 1'b1;
        repeat (5) @(posedge clk);
        link_pin_n <= 1'b1;
        link_run <= 1'b1;
        repeat (10) @(posedge clk);
    endtask
    task automatic pin_pulse();
        @(posedge clk);
        link_pin_n <= 1'b0;
        repeat (8) @(posedge clk);
        chk("power down", 1, 32'(power_down));
        link_pin_n <= 1'b1;
        repeat (10) @(posedge clk);
    endtask
    function automatic int exp_bclk(input logic [1:0] m, input int r,
                                    input int nr);
        int lk;
        lk = (m == SPLC_DSP) ? SPLC_DSP_BCLK_KHZ : SPLC_PRI_BCLK_KHZ;
        return nr * lk / ((r == 1) ? SPLC_REF1_KHZ : SPLC_REF0_KHZ);
    endfunction
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // the whole run is about 16000 cycles, most of it one dsp frame
    initial begin
        #300000;
        n_mismatch++;
        give_verdict();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(81142));
        for (int m = 3; m >= 0; m--) begin
            mb = 2'(m);
            power_up(~mb[1], ~mb[0]);
            chk("mode", 32'(mb), 32'(mode_out));
            chk("bclk oe", 32'(mb inside {0, 3}), 32'(bitclk_oe));
            chk("fsync oe", 32'(mb == 3), 32'(fsync_oe));
            apb(1'b0, SPLC_STATUS_OFF, 32'h0);
            chk("status", {29'h1, mb}, rd & 32'h7);
            strap_hi <= mb[1];
            strap_lo <= mb[0];
            pin_pulse();
            chk("mode kept", 32'(mb), 32'(mode_out));
            repeat (30) begin
                @(posedge clk);
                tx_bit <= 1'($urandom);
                @(negedge clk);
                chk("sdata out", 32'(tx_sh), 32'(sd_out));
                chk("sdata in", 32'(sd_p2), 32'(rx_bit));
            end
            // secondaries run with the reference clock stopped
            ref_run = (mb == 0 || mb == 3);
            measure(400);
            if (ref_run)
                near("bclk", exp_bclk(mb, 0, nref), nbo);
            else begin
                near("bit rises", nbi, nbr);
                chk("xtal drive off", 0, 32'(xdrv));
            end
            if (mb != 3) begin
                near("frames", nfs, nfr);
            end else begin
                // a dsp frame is long, so this window holds one or two
                measure(13000);
                fr_ok = (nfs - nbo / SPLC_FS_DIV) inside {0, 1};
                chk("dsp frames", 1, 32'(fr_ok));
                chk("dsp frame rise", 0, nfr);
            end
            ref_run = 1'b1;
        end
        // primary: register map, rate field, clock out, power-down
        apb(1'b0, SPLC_CTRL_OFF, 32'h0);
        chk("ctrl reset", SPLC_CTRL_RESET, rd);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped err", 1, 32'(er));
        wd = ($urandom & ~SPLC_CTRL_MASK) | 32'h17;
        apb(1'b1, SPLC_CTRL_OFF, wd);
        ref_half = 20.345;
        measure(400);
        near("bclk rate1", exp_bclk(SPLC_PRIMARY, 1, nref), nbo);
        near("clock out", nref, ncko);
        @(posedge clk);
        link_pin_n <= 1'b0;
        // let the request cross the synchroniser before counting edges
        repeat (10) @(posedge clk);
        measure(200);
        chk("bclk in pd", 0, 32'(nbo));
        chk("clock out in pd", 0, 32'(ncko));
        link_pin_n <= 1'b1;
        repeat (10) @(posedge clk);
        apb(1'b0, SPLC_CTRL_OFF, 32'h0);
        chk("ctrl kept", wd & SPLC_CTRL_MASK, rd);
        chk("mode kept pd", 32'(SPLC_PRIMARY), 32'(mode_out));
        apb(1'b1, SPLC_CTRL_OFF, 32'h1);
        measure(200);
        chk("clock out off", 0, 32'(ncko));
        give_verdict();
    end
endmodule // testbench
